// >>> dv/pad_world.sv
`timescale 1ns/1ns
`default_nettype none
// far side of the group: pads seen from outside the chip
module pad_world (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] ext_level,
	input wire logic [4:0] dbg_out,
	input wire logic [4:0] dbg_oe_n,
	input wire logic [4:0] dbg_ext,
	output logic [7:0] pin_in,
	output logic [4:0] dbg_in
);
	// a driven pad shows the mux level; a released one what the board puts on it
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
		end
		for (int i = 0; i < 5; i++) begin
			dbg_in[i] = dbg_oe_n[i] ? dbg_ext[i] : dbg_out[i];
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_port_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none
module tb_port_pin_mux;
	import pin_mux_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rnd = 32'hE3227817, rd_v;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	reset_src_t reset_src = '0;
	logic power_save = 1'b0;
	periph_out_t periph = '0;
	logic [7:0] ext_level = 8'h00, pin_in, pin_out, pin_oe_n, held, fsel;
	logic [3:0] alt_in = 4'h0, cap_in, tsel, cap_held, dbg_core;
	logic [4:0] dbg_ext = 5'h00, dbg_in, dbg_out, dbg_oe_n;
	logic dbg_pd, dbg_do = 1'b0, dbg_fn, mem_oe_n;
	logic [10:0] wake_in = 11'h000, wake_out;
	logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
	logic [3:0] dbg_exp = 4'h6;
	int miscompares = 0;
	int cmp_count = 0;

	// 100 ns period
	always #50 aclk = ~aclk;

	port_pin_mux dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_src(reset_src),
		.power_save(power_save), .periph(periph), .group_pin_in(pin_in), .group_pin_out(pin_out),
		.group_pin_oe_n(pin_oe_n), .timer_alt_pin_in(alt_in), .timer_cap_in(cap_in),
		.debug_pin_in(dbg_in), .debug_pin_out(dbg_out), .debug_pin_oe_n(dbg_oe_n),
		.debug_pulldown_en(dbg_pd), .debug_data_out(dbg_do), .debug_reset_in(dbg_core[0]),
		.debug_data_in(dbg_core[1]), .debug_clock_in(dbg_core[2]), .debug_mode_select(dbg_core[3]),
		.debug_function(dbg_fn), .mem_pins_oe_n(mem_oe_n),
		.wake_in(wake_in), .wake_out(wake_out));

	pad_world pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .dbg_out(dbg_out),
		.dbg_oe_n(dbg_oe_n), .dbg_ext(dbg_ext), .pin_in(pin_in), .dbg_in(dbg_in));

	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a hung handshake ends the run instead of the simulation
	task automatic guard(input int n);
		if (n > 50) begin
			miscompares++;
			$display("wait limit hit at %0t", $time);
			tally_and_finish();
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// expected pad levels in alternative mode for a given select pattern
	function automatic logic [7:0] alt_exp(input periph_out_t p, input logic [5:0] f);
		logic [7:0] s, t;
		s = {p.stepper_b, p.stepper_a};
		t = {s[7:6], p.sound_out_aux, p.sound_out, p.timer_chan};
		for (int i = 0; i < 6; i++) begin
			if (f[i])
				s[i] = t[i];
		end
		return s;
	endfunction

	task automatic roll;
		rnd = lfsr(rnd);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	// both write channels offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		n = 0;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			n++;
			guard(n);
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		logic ta, tr;
		n = 0;
		tr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			rd_v = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			n++;
			guard(n);
		end
		rready <= 1'b0;
	endtask

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		settle(3);
		// state straight after reset
		chk(pin_oe_n, 8'hFF);
		rd(OFF_DIR);
		chk(rd_v, 32'h0000_00FF);
		rd(OFF_MODE);
		chk(rd_v, 32'h0);
		rd(8'h20);
		chk(resp, RESP_SLVERR);
		// port mode output is driven by the latch, input reads the pad
		wr(OFF_DIR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			roll();
			wr(OFF_OUT_LATCH, {24'h0, rnd[7:0]});
			settle(2);
			chk(pin_out, rnd[7:0]);
			chk(pin_oe_n, 8'h00);
		end
		wr(OFF_DIR, 32'hFF);
		roll();
		ext_level <= rnd[7:0];
		settle(4);
		rd(OFF_PIN_IN);
		chk(rd_v, {24'h0, ext_level});
		// alternative outputs with random selects and peripheral levels
		wr(OFF_MODE, 32'hFF);
		wr(OFF_DIR, 32'h0);
		for (int i = 0; i < 10; i++) begin
			roll();
			periph <= periph_out_t'(rnd[13:0]);
			fsel = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[23:16];
			wr(OFF_FSEL, {24'h0, fsel});
			settle(2);
			chk(pin_out, alt_exp(periph, fsel[5:0]));
			rd(OFF_FSEL);
			chk(rd_v, {26'h0, fsel[5:0]});
		end
		// alternative mode needs output direction
		wr(OFF_DIR, 32'hFF);
		settle(2);
		chk(pin_oe_n, 8'hFF);
		// timer inputs picked per channel from one of two pads
		wr(OFF_MODE, 32'h0);
		for (int i = 0; i < 4; i++) begin
			roll();
			ext_level <= rnd[7:0];
			alt_in <= rnd[11:8];
			tsel = rnd[15:12];
			wr(OFF_TSEL, {28'h0, tsel});
			settle(4);
			chk(cap_in, (alt_in & tsel) | (ext_level[3:0] & ~tsel));
		end
		// power save freezes outputs, wake inputs keep passing
		wr(OFF_MODE, 32'hFF);
		wr(OFF_DIR, 32'h0);
		wr(OFF_FSEL, 32'h0);
		wr(OFF_TSEL, 32'hF);
		settle(2);
		held = pin_out;
		cap_held = cap_in;
		power_save <= 1'b1;
		settle(1);
		roll();
		// every stepper level flips, so a leak shows on all eight pads
		periph <= periph_out_t'({~held[3:0], ~held[7:4], 6'h00});
		wake_in <= rnd[10:0];
		alt_in <= ~alt_in;
		wr(OFF_MODE, 32'h0);
		settle(3);
		chk(pin_out, held);
		chk(cap_in, cap_held);
		chk(wake_out, wake_in);
		rd(OFF_STATUS);
		chk(rd_v, 32'h0000_0002);
		power_save <= 1'b0;
		settle(2);
		chk(pin_out, alt_exp(periph, 6'h00));
		rd(OFF_MODE);
		chk(rd_v, 32'hFF);
		// reset sources in turn, debug ownership tracked across them
		for (int i = 0; i < 4; i++) begin
			wr(OFF_MEM_CTRL, 32'h1);
			wr(OFF_DIR, 32'h0);
			settle(2);
			chk(mem_oe_n, 1'b0);
			reset_src <= reset_src_t'(codes[i]);
			settle(1);
			chk(pin_oe_n, 8'hFF);
			chk(dbg_oe_n, 5'h1F);
			chk(dbg_pd, 1'b1);
			reset_src <= '0;
			roll();
			dbg_do <= rnd[0];
			dbg_ext <= rnd[5:1];
			settle(3);
			chk(dbg_fn, dbg_exp[i]);
			chk(mem_oe_n, 1'b1);
			chk(pin_oe_n, 8'hFF);
			chk(dbg_oe_n, dbg_exp[i] ? 5'h1B : 5'h1F);
			chk(dbg_in[2], dbg_exp[i] & dbg_do);
			chk(dbg_core, dbg_exp[i] ? {dbg_ext[4:3], dbg_ext[1:0]} : 4'h0);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> logic/pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;
	// geometry of the port group
	localparam int NUM_PINS = 8;
	localparam int FSEL_PINS = 6;
	localparam int STEP_W = 4;
	localparam int DBG_PINS = 5;
	localparam int WAKE_W = 11;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_OUT_LATCH = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DIR = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_FSEL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_PIN_IN = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TSEL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_MEM_CTRL = 8'h1C;

	// reset values
	localparam logic [NUM_PINS-1:0] OUT_LATCH_RST = 8'h00;
	localparam logic [NUM_PINS-1:0] DIR_RST = 8'hFF;
	localparam logic [NUM_PINS-1:0] MODE_RST = 8'h00;
	localparam logic [FSEL_PINS-1:0] FSEL_RST = 6'h00;
	localparam logic [STEP_W-1:0] TSEL_RST = 4'h0;

	// status fields
	localparam int ST_DEBUG_FN = 0;
	localparam int ST_PSAVE = 1;
	localparam int ST_IN_RESET = 2;

	// debug pin positions
	localparam int DBG_RESET = 0;
	localparam int DBG_DATA_IN = 1;
	localparam int DBG_DATA_OUT = 2;
	localparam int DBG_CLOCK = 3;
	localparam int DBG_MODE = 4;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// peripheral outputs offered to the pins
	typedef struct packed {
		logic [STEP_W-1:0] stepper_a;
		logic [STEP_W-1:0] stepper_b;
		logic [STEP_W-1:0] timer_chan;
		logic sound_out;
		logic sound_out_aux;
	} periph_out_t;

	// reset source levels from the reset controller
	typedef struct packed {
		logic por;
		logic ext;
		logic internal;
	} reset_src_t;
endpackage
`default_nettype wire

// >>> logic/port_pin_mux.sv
// Contract
// - eight pins, each selectable as general port or alternative function.
// - mode bit 0 port, 1 alternative; alternative needs direction 0; select picks output.
// - first alternative: pins 0-3 stepper A outputs, pins 4-7 stepper B outputs.
// - second alternative: pins 0-3 carry timer channel outputs 1-4 in order.
// - second alternative: pin 4 sound output, pin 5 auxiliary sound output.
// - pins 6 and 7 have no select bit; alternative always routes stepper.
// - each timer input comes from one of two pins, chosen by a select.
// - after any reset release all pins come up in input port mode.
// - during any reset every pin except the debug reset pin is high impedance; group and memory pins only from the first clock edge in reset.
// - during any reset the debug reset pin is a port input with pull-down.
// - after power-on clear the debug pins come up as input ports.
// - after other internal resets the debug pins keep their previous function.
// - after any reset all external memory interface pins are inputs.
// - halt state leaves every pin function, direction and level untouched.
// - in power-save modes outputs stay valid and hold their entry levels.
// - in power-save modes only wake-up inputs stay active; others ignored.
// - wake-up inputs are eight interrupts, the non-maskable interrupt, two CAN inputs.
// - on power-save release every pin keeps its prior configuration and state.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module port_pin_mux #(
	parameter int PINS = pin_mux_pkg::NUM_PINS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pin_mux_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pin_mux_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire pin_mux_pkg::reset_src_t reset_src,
	input wire logic power_save,
	input wire pin_mux_pkg::periph_out_t periph,
	input wire logic [pin_mux_pkg::NUM_PINS-1:0] group_pin_in,
	output logic [pin_mux_pkg::NUM_PINS-1:0] group_pin_out,
	output logic [pin_mux_pkg::NUM_PINS-1:0] group_pin_oe_n,
	input wire logic [pin_mux_pkg::STEP_W-1:0] timer_alt_pin_in,
	output logic [pin_mux_pkg::STEP_W-1:0] timer_cap_in,
	input wire logic [pin_mux_pkg::DBG_PINS-1:0] debug_pin_in,
	output logic [pin_mux_pkg::DBG_PINS-1:0] debug_pin_out,
	output logic [pin_mux_pkg::DBG_PINS-1:0] debug_pin_oe_n,
	output logic debug_pulldown_en,
	input wire logic debug_data_out,
	output logic debug_reset_in,
	output logic debug_data_in,
	output logic debug_clock_in,
	output logic debug_mode_select,
	output logic debug_function,
	output logic mem_pins_oe_n,
	input wire logic [pin_mux_pkg::WAKE_W-1:0] wake_in,
	output logic [pin_mux_pkg::WAKE_W-1:0] wake_out
);
	import pin_mux_pkg::*;

	localparam int SYNC_W = NUM_PINS + STEP_W + DBG_PINS + WAKE_W;

	typedef struct packed {
		logic [NUM_PINS-1:0] out_latch;
		logic [NUM_PINS-1:0] dir;
		logic [NUM_PINS-1:0] mode;
		logic [FSEL_PINS-1:0] fsel;
		logic [STEP_W-1:0] tsel;
		logic mem_en;
		logic debug_fn;
		logic [NUM_PINS-1:0] pad_out;
		logic [NUM_PINS-1:0] pad_oe_n;
		logic [NUM_PINS-1:0] pin_in;
		logic [STEP_W-1:0] tcap;
		logic [3:0] dbg_core;
		logic dbg_dout;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [DATA_W-1:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} mux_state_t;

	localparam mux_state_t ST_RST = '{
		out_latch: OUT_LATCH_RST, dir: DIR_RST, mode: MODE_RST, fsel: FSEL_RST,
		tsel: TSEL_RST, pad_oe_n: '1, default: '0};

	mux_state_t st_reg;
	mux_state_t st_next;
	logic [SYNC_W-1:0] sync_q;
	logic [NUM_PINS-1:0] pin_s;
	logic [STEP_W-1:0] talt_s;
	logic [DBG_PINS-1:0] dbg_s;
	logic any_rst;
	logic write_go;

	// pad levels cross into aclk through two flops
	sync2 #(
		.WIDTH(SYNC_W)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({group_pin_in, timer_alt_pin_in, debug_pin_in, wake_in}),
		.q(sync_q)
	);

	// wake sources
	// wake inputs bypass the power-save gating below
	assign {pin_s, talt_s, dbg_s, wake_out} = sync_q;

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		addr_known = (a == OFF_OUT_LATCH) || (a == OFF_DIR) || (a == OFF_MODE) ||
			(a == OFF_FSEL) || (a == OFF_PIN_IN) || (a == OFF_TSEL) ||
			(a == OFF_STATUS) || (a == OFF_MEM_CTRL);
	endfunction

	function automatic logic [DATA_W-1:0] zext(input logic [NUM_PINS-1:0] v);
		zext = {{(DATA_W - NUM_PINS){1'b0}}, v};
	endfunction

	function automatic logic first_alt(input int i, input periph_out_t p);
		first_alt = (i < STEP_W) ? p.stepper_a[i % STEP_W] : p.stepper_b[i % STEP_W];
	endfunction

	function automatic logic second_alt(input int i, input periph_out_t p);
		if (i < STEP_W) begin
			second_alt = p.timer_chan[i % STEP_W];
		end else if (i == STEP_W) begin
			second_alt = p.sound_out;
		end else begin
			second_alt = p.sound_out_aux;
		end
	endfunction

	assign any_rst = reset_src.por | reset_src.ext | reset_src.internal;
	assign write_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;

	// handshake readies straight from state
	assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.w_held && !st_reg.bvalid;
	assign s_axi_arready = !st_reg.rvalid;

	// next state: bus slave, reset sources, pin routing
	always_comb begin
		st_next = st_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_held = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb0 = s_axi_wstrb[0];
		end
		// writes land only outside reset and power save, so config survives power save; reset reloads it
		if (write_go) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = addr_known(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (st_reg.wstrb0 && !any_rst && !power_save) begin
				case (st_reg.aw_addr)
					OFF_OUT_LATCH: begin
						st_next.out_latch = st_reg.wdata[NUM_PINS-1:0];
					end
					OFF_DIR: begin
						st_next.dir = st_reg.wdata[NUM_PINS-1:0];
					end
					OFF_MODE: begin
						st_next.mode = st_reg.wdata[NUM_PINS-1:0];
					end
					OFF_FSEL: begin
						st_next.fsel = st_reg.wdata[FSEL_PINS-1:0];
					end
					OFF_TSEL: begin
						st_next.tsel = st_reg.wdata[STEP_W-1:0];
					end
					OFF_MEM_CTRL: begin
						st_next.mem_en = st_reg.wdata[0];
					end
					default: begin
					end
				endcase
			end
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFF_OUT_LATCH: st_next.rdata = zext(st_reg.out_latch);
				OFF_DIR: st_next.rdata = zext(st_reg.dir);
				OFF_MODE: st_next.rdata = zext(st_reg.mode);
				OFF_FSEL: st_next.rdata = zext({2'h0, st_reg.fsel});
				OFF_PIN_IN: st_next.rdata = zext(st_reg.pin_in);
				OFF_TSEL: st_next.rdata = zext({4'h0, st_reg.tsel});
				OFF_STATUS: begin
					st_next.rdata = '0;
					st_next.rdata[ST_DEBUG_FN] = st_reg.debug_fn;
					st_next.rdata[ST_PSAVE] = power_save;
					st_next.rdata[ST_IN_RESET] = any_rst;
				end
				OFF_MEM_CTRL: st_next.rdata = zext({7'h00, st_reg.mem_en});
				default: st_next.rdata = '0;
			endcase
		end

		// halt neutral
		// halt has no input here: nothing below depends on it
		// outputs held
		if (!power_save) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (st_reg.mode[i]) begin
					if (i < FSEL_PINS && st_reg.fsel[i % FSEL_PINS]) begin
						st_next.pad_out[i] = second_alt(i, periph);
					end else begin
						st_next.pad_out[i] = first_alt(i, periph);
					end
				end else begin
					st_next.pad_out[i] = st_reg.out_latch[i];
				end
			end
			st_next.pad_oe_n = st_reg.dir;
			st_next.pin_in = pin_s;
			for (int k = 0; k < STEP_W; k++) begin
				st_next.tcap[k] = st_reg.tsel[k] ? talt_s[k] : pin_s[k];
			end
			st_next.dbg_core = st_reg.debug_fn ?
				{dbg_s[DBG_MODE], dbg_s[DBG_CLOCK], dbg_s[DBG_DATA_IN], dbg_s[DBG_RESET]} : 4'h0;
			st_next.dbg_dout = debug_data_out;
		end

		if (any_rst) begin
			st_next.out_latch = OUT_LATCH_RST;
			st_next.dir = DIR_RST;
			st_next.mode = MODE_RST;
			st_next.fsel = FSEL_RST;
			st_next.tsel = TSEL_RST;
			st_next.mem_en = 1'b0;
			st_next.pad_oe_n = '1;
			st_next.pad_out = '0;
			st_next.dbg_core = 4'h0;
			if (reset_src.por) begin
				st_next.debug_fn = 1'b0;
			end else if (reset_src.ext) begin
				st_next.debug_fn = 1'b1;
			end
			// internal keeps
			// an internal-only reset leaves debug_fn as it was
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// output ports from state
	assign group_pin_out = st_reg.pad_out;
	assign group_pin_oe_n = st_reg.pad_oe_n;
	assign timer_cap_in = st_reg.tcap;
	assign {debug_mode_select, debug_clock_in, debug_data_in, debug_reset_in} = st_reg.dbg_core;
	assign debug_function = st_reg.debug_fn;
	assign mem_pins_oe_n = !st_reg.mem_en;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;

	// debug reset pulldown
	// pull-down is on in reset and in debug use; only data-out ever drives
	assign debug_pulldown_en = any_rst || st_reg.debug_fn;
	assign debug_pin_out = {2'h0, st_reg.dbg_dout, 2'h0};
	assign debug_pin_oe_n = {2'h3, !st_reg.debug_fn || any_rst, 2'h3};

	// ---- checks ----
	sequence s_release;
		any_rst ##1 !any_rst;
	endsequence

	property p_reset_hiz;
		@(posedge aclk) disable iff (!aresetn)
		any_rst |-> (debug_pin_oe_n == '1) ##1 (group_pin_oe_n == '1);
	endproperty
	a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven during reset");

	property p_reset_pulldown;
		@(posedge aclk) disable iff (!aresetn)
		any_rst |-> debug_pulldown_en && debug_pin_oe_n[DBG_RESET];
	endproperty
	a_reset_pulldown: assert property (p_reset_pulldown) else $error("debug reset pin not pulled down");

	property p_input_after;
		@(posedge aclk) disable iff (!aresetn)
		s_release |-> (st_reg.dir == DIR_RST) && (st_reg.mode == MODE_RST) && (group_pin_oe_n == '1);
	endproperty
	a_input_after: assert property (p_input_after) else $error("pins not input after reset");

	property p_por_ports;
		@(posedge aclk) disable iff (!aresetn)
		reset_src.por ##1 !any_rst |-> !debug_function;
	endproperty
	a_por_ports: assert property (p_por_ports) else $error("debug pins active after power-on clear");

	property p_ext_debug;
		@(posedge aclk) disable iff (!aresetn)
		(reset_src.ext && !reset_src.por) ##1 !any_rst |-> debug_function ##1 !debug_pin_oe_n[DBG_DATA_OUT];
	endproperty
	a_ext_debug: assert property (p_ext_debug) else $error("debug pins not enabled after external reset");

	property p_int_keep;
		@(posedge aclk) disable iff (!aresetn)
		(reset_src.internal && !reset_src.por && !reset_src.ext) |=> $stable(debug_function);
	endproperty
	a_int_keep: assert property (p_int_keep) else $error("internal reset changed debug function");

	property p_mem_input;
		@(posedge aclk) disable iff (!aresetn)
		s_release |-> mem_pins_oe_n;
	endproperty
	a_mem_input: assert property (p_mem_input) else $error("memory pins driven after reset");

	property p_psave_hold;
		@(posedge aclk) disable iff (!aresetn)
		(power_save && !any_rst) |=> $stable(group_pin_out) && $stable(group_pin_oe_n);
	endproperty
	a_psave_hold: assert property (p_psave_hold) else $error("outputs moved in power save");

	property p_psave_inputs;
		@(posedge aclk) disable iff (!aresetn)
		(power_save && !any_rst) |=> $stable(st_reg.pin_in) && $stable(timer_cap_in);
	endproperty
	a_psave_inputs: assert property (p_psave_inputs) else $error("ignored input passed in power save");

	property p_psave_config;
		@(posedge aclk) disable iff (!aresetn)
		(power_save && !any_rst) [*2] |-> $stable(st_reg.mode) && $stable(st_reg.dir) && $stable(st_reg.fsel);
	endproperty
	a_psave_config: assert property (p_psave_config) else $error("config changed in power save");

	property p_stepper_pin0;
		@(posedge aclk) disable iff (!aresetn)
		(!any_rst && !power_save && st_reg.mode[0] && !st_reg.fsel[0]) |=> group_pin_out[0] == $past(periph.stepper_a[0]);
	endproperty
	a_stepper_pin0: assert property (p_stepper_pin0) else $error("pin 0 not stepper A");

	property p_timer_pin3;
		@(posedge aclk) disable iff (!aresetn)
		(!any_rst && !power_save && st_reg.mode[3] && st_reg.fsel[3]) |=> group_pin_out[3] == $past(periph.timer_chan[3]);
	endproperty
	a_timer_pin3: assert property (p_timer_pin3) else $error("pin 3 not timer channel 4");

	property p_sound_pin5;
		@(posedge aclk) disable iff (!aresetn)
		(!any_rst && !power_save && st_reg.mode[5] && st_reg.fsel[5]) |=> group_pin_out[5] == $past(periph.sound_out_aux);
	endproperty
	a_sound_pin5: assert property (p_sound_pin5) else $error("pin 5 not aux sound");

	property p_pin7_stepper;
		@(posedge aclk) disable iff (!aresetn)
		(!any_rst && !power_save && st_reg.mode[7]) |=> group_pin_out[7] == $past(periph.stepper_b[3]);
	endproperty
	a_pin7_stepper: assert property (p_pin7_stepper) else $error("pin 7 not stepper B out 4");

	property p_port_drive;
		@(posedge aclk) disable iff (!aresetn)
		(!any_rst && !power_save && !st_reg.mode[1]) |=>
			group_pin_out[1] == $past(st_reg.out_latch[1]) && group_pin_oe_n[1] == $past(st_reg.dir[1]);
	endproperty
	a_port_drive: assert property (p_port_drive) else $error("port pin not latch driven");

	property p_alt_dir;
		@(posedge aclk) disable iff (!aresetn)
		(!any_rst && !power_save && st_reg.mode[2] && st_reg.dir[2]) |=> group_pin_oe_n[2];
	endproperty
	a_alt_dir: assert property (p_alt_dir) else $error("alternative pin driven with direction set");

	property p_timer_sel;
		@(posedge aclk) disable iff (!aresetn)
		(!any_rst && !power_save && st_reg.tsel[1]) |=> timer_cap_in[1] == $past(talt_s[1]);
	endproperty
	a_timer_sel: assert property (p_timer_sel) else $error("timer input not from selected pin");
endmodule
`default_nettype wire

// >>> logic/sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	// first stage feeds only the second stage
	always_comb begin
		st_next.meta = d;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.stable;
endmodule
`default_nettype wire
